// [dv/adc_feed_model.sv]
// Behavioural converter source of sample sets
`timescale 1ns/100ps
`default_nettype none

module adc_feed_model (
  // Clock and request
  input  wire logic                       clk_i,
  input  wire logic                       go_i,
  input  wire front_end_pkg::adc_set_type set_i,
  // Sample set out
  output logic                            valid_o = 1'b0,
  output var front_end_pkg::adc_set_type  data_o = '0
);
  // One-cycle strobe; lines toggle between sets
  always @(posedge clk_i) begin
    valid_o <= go_i;
    data_o  <= go_i ? set_i : ~data_o;
  end
endmodule : adc_feed_model

`default_nettype wire

// [dv/channel_front_end_sva.sv]
// Port checker of the channel front end
`timescale 1ns/100ps
`default_nettype none

module channel_front_end_sva (
  // Clock and control
  input wire logic                          CLK_I,
  input wire logic                          RESET_I,
  input wire logic                          CE_I,
  // Requests
  input wire logic                          ADC_VALID_I,
  input wire logic                          REG_WR_I,
  input wire logic                          REG_RD_I,
  input wire logic [7:0]                    REG_ADDR_I,
  // Answers
  input wire logic [31:0]                   REG_RDATA_O,
  input wire logic                          REG_RVALID_O,
  input wire logic                          DSP_VALID_O,
  input wire front_end_pkg::dsp_set_type    DSP_DATA_O,
  input wire front_end_pkg::sample_set_type WAVE_SAMPLE_O,
  input wire logic                          IRQ_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  // ----------------------------------------------------------------
  // Sample set steps
  // ----------------------------------------------------------------
  sequence s_take;
    ADC_VALID_I && CE_I;
  endsequence
  sequence s_out;
    ##3 DSP_VALID_O;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_set_latency: assert property (s_take |-> s_out)
    else $error("set answer late");
  a_dsp_pulse: assert property (DSP_VALID_O && CE_I |=> !DSP_VALID_O)
    else $error("set strobe too long");
  a_wave_hold: assert property (!DSP_VALID_O && !$past(RESET_I)
    |-> $stable(WAVE_SAMPLE_O)) else $error("sample moved");
  a_dsp_hold: assert property (!DSP_VALID_O && !$past(RESET_I)
    |-> $stable(DSP_DATA_O)) else $error("stream moved");
  a_wave_match: assert property (DSP_VALID_O &&
    DSP_DATA_O[0][27:23] == {5{DSP_DATA_O[0][27]}}
    |-> WAVE_SAMPLE_O[0] == DSP_DATA_O[0][23:0]) else $error("sample off");
  a_read_answer: assert property (REG_RD_I && CE_I |=> REG_RVALID_O)
    else $error("read not answered");
  a_read_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("stray read answer");
  a_rdata_hold: assert property (!REG_RVALID_O && !$past(RESET_I)
    |-> $stable(REG_RDATA_O)) else $error("read data moved");
  a_gain_format: assert property (REG_RVALID_O &&
    $past(REG_ADDR_I) < 8'h08
    |-> REG_RDATA_O[31:24] == {4'h0, {4{REG_RDATA_O[23]}}})
    else $error("gain word format");
  a_sample_format: assert property (REG_RVALID_O &&
    $past(REG_ADDR_I) inside {[8'h08:8'h0b]}
    |-> REG_RDATA_O[31:24] == {8{REG_RDATA_O[23]}})
    else $error("sample word format");
  a_irq_cause: assert property ($rose(IRQ_O) |-> DSP_VALID_O ||
    $past(REG_WR_I) || $past(REG_WR_I, 2)) else $error("stray interrupt");
endmodule : channel_front_end_sva

bind channel_front_end channel_front_end_sva sva_u (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I),
  .ADC_VALID_I(ADC_VALID_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_RDATA_O(REG_RDATA_O),
  .REG_RVALID_O(REG_RVALID_O), .DSP_VALID_O(DSP_VALID_O),
  .DSP_DATA_O(DSP_DATA_O), .WAVE_SAMPLE_O(WAVE_SAMPLE_O), .IRQ_O(IRQ_O)
);

`default_nettype wire

// [dv/channel_front_end_tb.sv]
// Self-checking bench of the channel front end
`timescale 1ns/100ps
`default_nettype none
`include "front_end_consts.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  fail_count++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module channel_front_end_tb;
  logic                          clk, reset, reg_wr, reg_rd, go, rvalid, ce;
  logic                          adc_valid, dsp_valid, irq;
  logic [7:0]                    reg_addr;
  logic [31:0]                   reg_wdata, rdata;
  front_end_pkg::adc_set_type    feed, adc_data, xin, gtab;
  front_end_pkg::dsp_set_type    dsp_data, etab;
  front_end_pkg::sample_set_type wave;
  int                            fail_count = 0;
  int                            checks_done = 0;

  channel_front_end dut_u (
    .CLK_I(clk), .RESET_I(reset), .CE_I(ce),
    .ADC_VALID_I(adc_valid), .ADC_DATA_I(adc_data),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .DSP_VALID_O(dsp_valid), .DSP_DATA_O(dsp_data),
    .WAVE_SAMPLE_O(wave), .IRQ_O(irq)
  );

  adc_feed_model feed_u (
    .clk_i(clk), .go_i(go), .set_i(feed),
    .valid_o(adc_valid), .data_o(adc_data)
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic check_read(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHECK(rvalid, 1'b1)
    `CHECK(rdata, e)
  endtask : check_read

  task automatic send_set(input front_end_pkg::adc_set_type s);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    feed <= s;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (dsp_valid !== 1'b1 && n < 20);
    `CHECK(dsp_valid, 1'b1)
  endtask : send_set

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #(60000 * 20);
    fail_count++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    feed = '0;
    gtab = {24'h000000, 24'hc00000, 24'h400000, 24'h400000,
            24'h000000, 24'hc00000, 24'h400000};
    etab = {28'h0100000, 28'h0080000, 28'h0180000, 28'h0180000,
            28'h0100000, 28'h0080000, 28'h0180000};
    for (int i = 0; i < 7; i++) begin
      xin[i] = 24'(24'sh0a0000 - 24'sh040000 * i);
    end
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    check_read(`ADDR_SETUP_REGISTER_THREE, 32'h00000001);
    check_read(`ADDR_MAIN_CONFIG, 32'h00000000);
    check_read(`ADDR_INTEGRATOR_COEFFICIENT, 32'h00000000);
    check_read(`ADDR_EVENT_FLAGS_ZERO, 32'h00000000);
    reg_write(`ADDR_SETUP_REGISTER_THREE, 32'h00000000);
    reg_write(`ADDR_INTEGRATOR_COEFFICIENT, 32'h0fff8000);
    check_read(`ADDR_INTEGRATOR_COEFFICIENT, 32'h0fff8000);
    send_set(xin);
    for (int i = 0; i < 7; i++) begin
      `CHECK(dsp_data[i], front_end_pkg::dsp_word_type'(xin[i]))
    end
    `CHECK(wave[3], xin[3])
    check_read(`ADDR_NEUTRAL_CURRENT_SAMPLE, 32'hfffe0000);
    reg_write(`ADDR_PHASE_A_CURRENT_SAMPLE, 32'h00000000);
    check_read(`ADDR_PHASE_A_CURRENT_SAMPLE, 32'h000a0000);
    check_read(8'h10, 32'h00000000);
    check_read(`ADDR_EVENT_FLAGS_ZERO, 32'h00020000);
    `CHECK(irq, 1'b0)
    reg_write(`ADDR_EVENT_MASK_ZERO, 32'h00020000);
    repeat (2) @(negedge clk);
    `CHECK(irq, 1'b1)
    reg_write(`ADDR_EVENT_FLAGS_ZERO, 32'h00020000);
    repeat (2) @(negedge clk);
    `CHECK(irq, 1'b0)
    send_set(xin);
    `CHECK(irq, 1'b1)
    reg_write(`ADDR_EVENT_MASK_ZERO, 32'h00000000);
    for (int i = 0; i < 7; i++) begin
      reg_write(8'(i), {8'h00, gtab[i]});
    end
    send_set({7{24'sh100000}});
    for (int i = 0; i < 7; i++) begin
      `CHECK(dsp_data[i], etab[i])
    end
    check_read(`ADDR_PHASE_A_CURRENT_SAMPLE, 32'h00180000);
    check_read(`ADDR_PHASE_B_CURRENT_GAIN, 32'h0fc00000);
    check_read(`ADDR_PHASE_B_VOLTAGE_GAIN, 32'h0fc00000);
    @(posedge clk);
    ce <= 1'b0;
    reg_write(`ADDR_EVENT_MASK_ZERO, 32'h00020000);
    ce <= 1'b1;
    check_read(`ADDR_EVENT_MASK_ZERO, 32'h00000000);
    `CHECK(irq, 1'b0)
    reg_write(`ADDR_MAIN_CONFIG, 32'h00000001);
    repeat (2) send_set({7{24'sh100000}});
    `CHECK(dsp_data[0] !== etab[0], 1'b1)
    `CHECK(dsp_data[3], etab[3])
    `CHECK(dsp_data[4], etab[4])
    reg_write(`ADDR_SETUP_REGISTER_THREE, 32'h00000008);
    repeat (2) send_set({7{24'sh100000}});
    `CHECK(dsp_data[3] !== etab[3], 1'b1)
    reg_write(`ADDR_MAIN_CONFIG, 32'h00000000);
    reg_write(`ADDR_SETUP_REGISTER_THREE, 32'h00000001);
    repeat (3000) send_set({7{24'sh100000}});
    for (int i = 0; i < 7; i++) begin
      `CHECK(dsp_data[i] < 28'sh1000 && dsp_data[i] > -28'sh1000, 1'b1)
    end
    print_verdict();
  end
endmodule : channel_front_end_tb

`default_nettype wire

// [hdl/channel_front_end.sv]
// Seven-channel gain and DC filter block with integrators and sample registers on channels 0..3
`timescale 1ns/100ps
`default_nettype none
`include "front_end_consts.svh"

module channel_front_end (
  // Clock, reset and enable
  input  wire logic                          CLK_I,
  input  wire logic                          RESET_I,
  input  wire logic                          CE_I,
  // ADC samples: 0..2 phase currents, 3 neutral, 4..6 phase voltages
  input  wire logic                          ADC_VALID_I,
  input  wire front_end_pkg::adc_set_type    ADC_DATA_I,
  // Register port
  input  wire logic                          REG_WR_I,
  input  wire logic                          REG_RD_I,
  input  wire logic [7:0]                    REG_ADDR_I,
  input  wire logic [31:0]                   REG_WDATA_I,
  output logic [31:0]                        REG_RDATA_O,
  output logic                               REG_RVALID_O,
  // Processed channel stream to downstream computations
  output logic                               DSP_VALID_O,
  output var  front_end_pkg::dsp_set_type    DSP_DATA_O,
  // Stored waveform samples
  output var  front_end_pkg::sample_set_type WAVE_SAMPLE_O,
  // Interrupt
  output logic                               IRQ_O
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    front_end_pkg::seq_state_type  seq;
    front_end_pkg::reg_file_type   regs;
    front_end_pkg::sample_set_type samples;
    front_end_pkg::dsp_set_type    dsp_data;
    logic                          dsp_valid;
    logic [31:0]                   rdata;
    logic                          rvalid;
  } top_state_type;

  top_state_type state_ff;
  top_state_type nxt_state;

  front_end_pkg::reg_req_type   req;
  front_end_pkg::dsp_set_type   scaled;
  front_end_pkg::dsp_set_type   filtered;

  assign req.wr    = REG_WR_I;
  assign req.rd    = REG_RD_I;
  assign req.addr  = REG_ADDR_I;
  assign req.wdata = REG_WDATA_I;

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] gain_word(
    input front_end_pkg::adc_word_type g
  );
    gain_word = {4'h0, {4{g[23]}}, g};
  endfunction : gain_word

  function automatic logic [31:0] sample_word(
    input front_end_pkg::adc_word_type s
  );
    sample_word = {{8{s[23]}}, s};
  endfunction : sample_word

  function automatic front_end_pkg::adc_word_type to_sample(
    input front_end_pkg::dsp_word_type d
  );
    if (d > 28'sh07fffff) begin
      to_sample = 24'sh7fffff;
    end else if (d < -28'sh0800000) begin
      to_sample = 24'sh800000;
    end else begin
      to_sample = d[23:0];
    end
  endfunction : to_sample

  function automatic logic is_gain_addr(input logic [7:0] a);
    is_gain_addr = (a <= `ADDR_PHASE_C_VOLTAGE_GAIN);
  endfunction : is_gain_addr

  function automatic logic is_sample_addr(input logic [7:0] a);
    is_sample_addr = (a >= `ADDR_PHASE_A_CURRENT_SAMPLE) &&
                     (a <= `ADDR_NEUTRAL_CURRENT_SAMPLE);
  endfunction : is_sample_addr

  // --------------------------------------------------------------------
  // Channel datapaths
  // --------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 7; ch++) begin : g_chan
      logic int_en;

      if (ch < 3) begin : g_phase
        assign int_en = state_ff.regs.phase_int_en;
      end else if (ch == 3) begin : g_neutral
        assign int_en = state_ff.regs.neutral_int_en;
      end else begin : g_voltage
        assign int_en = 1'b0;
      end

      gain_scaler u_gain (
        .sample_i (ADC_DATA_I[ch]),
        .gain_i   (state_ff.regs.gain[ch]),
        .scaled_o (scaled[ch])
      );

      dc_integ_stage u_stage (
        .clk_i    (CLK_I),
        .reset_i  (RESET_I),
        .ce_i     (CE_I),
        .valid_i  (ADC_VALID_I),
        .data_i   (scaled[ch]),
        .hpf_en_i (state_ff.regs.dc_filter_en),
        .int_en_i (int_en),
        .coeff_i  (state_ff.regs.coefficient),
        .data_o   (filtered[ch])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic        ready_set;
  logic        ready_clr;
  logic [31:0] rd_word;

  always_comb begin
    nxt_state           = state_ff;
    nxt_state.dsp_valid = 1'b0;
    nxt_state.rvalid    = 1'b0;
    ready_set           = 1'b0;

    // Sample sequencing
    case (state_ff.seq)
      front_end_pkg::ST_IDLE: begin
        if (ADC_VALID_I) begin
          nxt_state.seq = front_end_pkg::ST_FILTER;
        end
      end
      front_end_pkg::ST_FILTER: begin
        nxt_state.seq = front_end_pkg::ST_LATCH;
      end
      front_end_pkg::ST_LATCH: begin
        nxt_state.dsp_data  = filtered;
        nxt_state.dsp_valid = 1'b1;
        for (int i = 0; i < 4; i++) begin
          nxt_state.samples[i] = to_sample(filtered[i]);
        end
        ready_set     = 1'b1;
        nxt_state.seq = ADC_VALID_I ? front_end_pkg::ST_FILTER
                                    : front_end_pkg::ST_IDLE;
      end
      default: begin
        nxt_state.seq = front_end_pkg::ST_IDLE;
      end
    endcase

    // Register writes
    ready_clr = 1'b0;
    if (req.wr) begin
      if (is_gain_addr(req.addr)) begin
        nxt_state.regs.gain[req.addr[2:0]] = req.wdata[23:0];
      end
      case (req.addr)
        `ADDR_INTEGRATOR_COEFFICIENT: begin
          nxt_state.regs.coefficient = req.wdata[23:0];
        end
        `ADDR_MAIN_CONFIG: begin
          nxt_state.regs.phase_int_en =
            req.wdata[`BIT_PHASE_INTEGRATOR_ENABLE];
        end
        `ADDR_SETUP_REGISTER_THREE: begin
          nxt_state.regs.dc_filter_en =
            req.wdata[`BIT_DC_FILTER_ENABLE];
          nxt_state.regs.neutral_int_en =
            req.wdata[`BIT_NEUTRAL_INTEGRATOR_ENABLE];
        end
        `ADDR_EVENT_FLAGS_ZERO: begin
          ready_clr = req.wdata[`BIT_SAMPLE_READY_FLAG];
        end
        `ADDR_EVENT_MASK_ZERO: begin
          nxt_state.regs.ready_mask = req.wdata[`BIT_SAMPLE_READY_FLAG];
        end
        default: begin
        end
      endcase
    end

    // Set wins over clear on the ready flag
    if (ready_set) begin
      nxt_state.regs.ready_flag = 1'b1;
    end else if (ready_clr) begin
      nxt_state.regs.ready_flag = 1'b0;
    end

    // Register reads
    rd_word = 32'h00000000;
    if (is_gain_addr(req.addr)) begin
      rd_word = gain_word(state_ff.regs.gain[req.addr[2:0]]);
    end else if (is_sample_addr(req.addr)) begin
      rd_word = sample_word(state_ff.samples[req.addr[1:0]]);
    end else begin
      case (req.addr)
        `ADDR_INTEGRATOR_COEFFICIENT: begin
          rd_word = gain_word(state_ff.regs.coefficient);
        end
        `ADDR_MAIN_CONFIG: begin
          rd_word[`BIT_PHASE_INTEGRATOR_ENABLE] =
            state_ff.regs.phase_int_en;
        end
        `ADDR_SETUP_REGISTER_THREE: begin
          rd_word[`BIT_DC_FILTER_ENABLE] = state_ff.regs.dc_filter_en;
          rd_word[`BIT_NEUTRAL_INTEGRATOR_ENABLE] =
            state_ff.regs.neutral_int_en;
        end
        `ADDR_EVENT_FLAGS_ZERO: begin
          rd_word[`BIT_SAMPLE_READY_FLAG] = state_ff.regs.ready_flag;
        end
        `ADDR_EVENT_MASK_ZERO: begin
          rd_word[`BIT_SAMPLE_READY_FLAG] = state_ff.regs.ready_mask;
        end
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      nxt_state.rdata  = rd_word;
      nxt_state.rvalid = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_ff                     <= '0;
      state_ff.seq                 <= front_end_pkg::ST_IDLE;
      for (int i = 0; i < 7; i++) begin
        state_ff.regs.gain[i]      <= `RST_GAIN;
      end
      state_ff.regs.coefficient    <= `RST_COEFFICIENT;
      state_ff.regs.phase_int_en   <= `RST_PHASE_INT_ENABLE;
      state_ff.regs.neutral_int_en <= `RST_NEUTRAL_INT_ENABLE;
      state_ff.regs.dc_filter_en   <= `RST_DC_FILTER_ENABLE;
    end else if (CE_I) begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign REG_RDATA_O   = state_ff.rdata;
  assign REG_RVALID_O  = state_ff.rvalid;
  assign DSP_VALID_O   = state_ff.dsp_valid;
  assign DSP_DATA_O    = state_ff.dsp_data;
  assign WAVE_SAMPLE_O = state_ff.samples;
  assign IRQ_O = state_ff.regs.ready_flag & state_ff.regs.ready_mask;

endmodule : channel_front_end
`default_nettype wire

// [hdl/dc_integ_stage.sv]
// DC blocking high-pass filter followed by an optional integrator
`timescale 1ns/100ps
`default_nettype none
`include "front_end_consts.svh"

module dc_integ_stage (
  // Clock and control
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         ce_i,
  // Sample in
  input  wire logic                         valid_i,
  input  wire front_end_pkg::dsp_word_type  data_i,
  // Settings
  input  wire logic                         hpf_en_i,
  input  wire logic                         int_en_i,
  input  wire front_end_pkg::adc_word_type  coeff_i,
  // Sample out
  output var  front_end_pkg::dsp_word_type  data_o
);

  typedef struct packed {
    logic signed [27:0] x_prev;
    logic signed [29:0] hpf_y;
    logic signed [31:0] int_acc;
    logic signed [27:0] out;
  } stage_state_type;

  stage_state_type state_ff;
  stage_state_type nxt_state;

  function automatic logic signed [27:0] sat28(input logic signed [53:0] v);
    if (v > 54'sh00000007ffffff) begin
      sat28 = 28'sh7ffffff;
    end else if (v < -54'sh00000008000000) begin
      sat28 = 28'sh8000000;
    end else begin
      sat28 = v[27:0];
    end
  endfunction : sat28

  logic signed [29:0] diff;
  logic signed [29:0] hpf_new;
  logic signed [27:0] filtered;
  logic signed [31:0] acc_new;
  logic signed [53:0] corr;

  always_comb begin
    nxt_state = state_ff;
    diff      = 30'(data_i) - 30'(state_ff.x_prev) + state_ff.hpf_y;
    hpf_new   = diff - (diff >>> `HPF_POLE_SHIFT);
    filtered  = hpf_en_i ? sat28(54'(hpf_new)) : data_i;
    acc_new   = state_ff.int_acc + 32'(filtered >>> `INT_INPUT_SHIFT)
                - (state_ff.int_acc >>> `INT_LEAK_SHIFT);
    corr      = (54'(filtered) * 54'(coeff_i)) >>> `COEFF_SCALE_SHIFT;
    if (valid_i) begin
      nxt_state.x_prev = data_i;
      nxt_state.hpf_y  = hpf_en_i ? hpf_new : 30'sh0;
      if (int_en_i) begin
        nxt_state.int_acc = acc_new;
        nxt_state.out     = sat28(54'(acc_new) + corr);
      end else begin
        nxt_state.int_acc = 32'sh0;
        nxt_state.out     = filtered;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= '0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  assign data_o = state_ff.out;

endmodule : dc_integ_stage
`default_nettype wire

// [hdl/front_end_consts.svh]
// Constants of the channel gain, DC filter and integrator front end
`ifndef FRONT_END_CONSTS_SVH
`define FRONT_END_CONSTS_SVH

// ----------------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------------
`define ADDR_PHASE_A_CURRENT_GAIN   8'h00
`define ADDR_PHASE_B_CURRENT_GAIN   8'h01
`define ADDR_PHASE_C_CURRENT_GAIN   8'h02
`define ADDR_NEUTRAL_CURRENT_GAIN   8'h03
`define ADDR_PHASE_A_VOLTAGE_GAIN   8'h04
`define ADDR_PHASE_B_VOLTAGE_GAIN   8'h05
`define ADDR_PHASE_C_VOLTAGE_GAIN   8'h06
`define ADDR_INTEGRATOR_COEFFICIENT 8'h07
`define ADDR_PHASE_A_CURRENT_SAMPLE 8'h08
`define ADDR_PHASE_B_CURRENT_SAMPLE 8'h09
`define ADDR_PHASE_C_CURRENT_SAMPLE 8'h0a
`define ADDR_NEUTRAL_CURRENT_SAMPLE 8'h0b
`define ADDR_MAIN_CONFIG            8'h0c
`define ADDR_SETUP_REGISTER_THREE   8'h0d
`define ADDR_EVENT_FLAGS_ZERO       8'h0e
`define ADDR_EVENT_MASK_ZERO        8'h0f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PHASE_INTEGRATOR_ENABLE   0
`define BIT_DC_FILTER_ENABLE          0
`define BIT_NEUTRAL_INTEGRATOR_ENABLE 3
`define BIT_SAMPLE_READY_FLAG         17

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_GAIN                24'h000000
`define RST_COEFFICIENT         24'h000000
`define RST_PHASE_INT_ENABLE    1'b0
`define RST_NEUTRAL_INT_ENABLE  1'b0
`define RST_DC_FILTER_ENABLE    1'b1

// ----------------------------------------------------------------------
// Filter shape and gain scale
// ----------------------------------------------------------------------
`define GAIN_FRACTION_BITS 23
`define HPF_POLE_SHIFT     8
`define INT_INPUT_SHIFT    4
`define INT_LEAK_SHIFT     10
`define COEFF_SCALE_SHIFT  23

`endif

// [hdl/front_end_pkg.sv]
// Types of the channel gain, DC filter and integrator front end
package front_end_pkg;

  typedef logic signed [23:0] adc_word_type;
  typedef logic signed [27:0] dsp_word_type;
  typedef adc_word_type [6:0] adc_set_type;
  typedef dsp_word_type [6:0] dsp_set_type;
  typedef adc_word_type [3:0] sample_set_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FILTER = 2'b01,
    ST_LATCH  = 2'b11
  } seq_state_type;

  typedef struct packed {
    adc_word_type [6:0] gain;
    adc_word_type       coefficient;
    logic               phase_int_en;
    logic               neutral_int_en;
    logic               dc_filter_en;
    logic               ready_flag;
    logic               ready_mask;
  } reg_file_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage : front_end_pkg

// [hdl/gain_scaler.sv]
// Fractional gain multiplier with saturation to the DSP word
`timescale 1ns/100ps
`default_nettype none
`include "front_end_consts.svh"

module gain_scaler (
  // Sample and gain
  input  wire front_end_pkg::adc_word_type sample_i,
  input  wire front_end_pkg::adc_word_type gain_i,
  // Scaled result
  output var  front_end_pkg::dsp_word_type scaled_o
);

  logic signed [24:0] factor;
  logic signed [48:0] product;
  logic signed [48:0] shifted;

  always_comb begin
    factor  = 25'sh0800000 + {gain_i[23], gain_i};
    product = sample_i * factor;
    shifted = product >>> `GAIN_FRACTION_BITS;
    if (shifted > 49'sh0000007ffffff) begin
      scaled_o = 28'sh7ffffff;
    end else if (shifted < -49'sh0000008000000) begin
      scaled_o = 28'sh8000000;
    end else begin
      scaled_o = shifted[27:0];
    end
  end

endmodule : gain_scaler
`default_nettype wire
